// File: fsk_host_model.sv
// Host model driving the register port, update and keying pins
`timescale 1ns/1ps
`default_nettype none
module fsk_host_model
  import fsk_pkg::*;
(
  // Clock
  input  wire logic  mclk_in,
  // Pins toward the engine
  output logic       wr_out,
  output logic       rd_out,
  output logic [5:0] addr_out,
  output logic [7:0] data_out,
  output logic       upd_out,
  output logic       key_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 6'h00;
    data_out = 8'h00;
    upd_out = 1'b0;
    key_out = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      wr_out <= 1'b1;
      addr_out <= a + 6'(i);
      data_out <= v[8*i+:8];
    end
    @(posedge mclk_in);
    wr_out <= 1'b0;
    data_out <= ~data_out;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge mclk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge mclk_in);
    rd_out <= 1'b0;
  endtask
  // Written values only act after this pulse
  task automatic pulse(input int w);
    @(posedge mclk_in);
    upd_out <= 1'b1;
    repeat (2) @(posedge mclk_in);
    upd_out <= 1'b0;
    repeat (w) @(posedge mclk_in);
  endtask
  task automatic key(input logic v);
    @(posedge mclk_in);
    key_out <= v;
  endtask
  task automatic sweep_clear(input logic [7:0] c);
    wr(ADDR_CONTROL, c | 8'h40, 1);
    pulse(8);
    wr(ADDR_CONTROL, c, 1);
    pulse(8);
  endtask
endmodule
`default_nettype wire

// File: fsk_pkg.sv
// Package for the frequency shift keying sweep engine
package fsk_pkg;

  // Byte addresses of the register port
  localparam logic [5:0] ADDR_LOW_TONE   = 6'h04;
  localparam logic [5:0] ADDR_HIGH_TONE  = 6'h0a;
  localparam logic [5:0] ADDR_STEP       = 6'h10;
  localparam logic [5:0] ADDR_INTERVAL   = 6'h1a;
  localparam logic [5:0] ADDR_CONTROL    = 6'h1f;

  // Control byte fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_TRI_BIT   = 5;
  localparam int CTRL_SCLR_BIT  = 6;
  localparam int CTRL_FCLR_BIT  = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int WORD_W     = 48;
  localparam int INTERVAL_W = 20;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 20'h0_0001;
  localparam logic [WORD_W-1:0] WORD_RESET = 48'h0000_0000_0000;

  typedef enum logic [2:0] {
    FSK_MODE_SINGLE  = 3'b000,
    FSK_MODE_KEYED   = 3'b001,
    FSK_MODE_RAMPED  = 3'b010,
    FSK_MODE_CHIRP   = 3'b011,
    FSK_MODE_PHASE   = 3'b100
  } fsk_mode_type;

  // Active register set, copied on update
  typedef struct packed {
    logic [WORD_W-1:0]     low_tone_word;
    logic [WORD_W-1:0]     high_tone_word;
    logic [WORD_W-1:0]     step_word;
    logic [INTERVAL_W-1:0] interval;
    logic [7:0]            control;
  } fsk_regs_type;

  // Byte-wide register write request
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] data;
  } fsk_wr_type;

endpackage

// File: fsk_rate_timer.sv
// Ramp interval down counter
`timescale 1ns/1ps
`default_nettype none
module fsk_rate_timer
  import fsk_pkg::*;
#(
  parameter int CNT_W = INTERVAL_W
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  // Control
  input  wire logic             run_in,
  input  wire logic             restart_in,
  input  wire logic [CNT_W-1:0] interval_in,
  // Tick
  output logic                  tick_out
);

  logic [CNT_W-1:0] count;

  // Reload with N on each zero gives N+1 cycles between ticks
  // Live interval value is reloaded so slope changes apply from the next reload
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      tick_out <= 1'b0;
      if (!run_in || restart_in) begin
        count <= interval_in;
      end else if (count == '0) begin
        count    <= interval_in;
        tick_out <= 1'b1;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: fsk_sweep_engine.sv
// Tuning word selection and ramped sweep engine
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Unramped mode: keying low selects low tone word, high selects high.
// - Word switches keep phase; only the phase increment changes.
// - Ramped mode steps through intermediate frequencies between the tone words.
// - Ramp timer is a 20-bit down counter pulsing once at zero.
// - Ramp timer starts whenever the keying input changes level, outside triangle sweep.
// - Ramp pulses are N+1 clocks apart, N from 1 to 2^20-1.
// - Each ramp pulse adds the step word into the sweep accumulator; the last one sets it to the span.
// - Accumulator is added to or subtracted from the start word.
// - At destination the timer stops and the output holds.
// - Early keying toggle reverses the ramp immediately, same rate and step.
// - Triangle bit sweeps continuously between words and ignores keying.
// - Triangle sweep starts at the word chosen by keying level.
// - New step or interval values apply to an ongoing ramp.
// - Sweep clear zeroes the accumulator for one clock, ramp restarts.
// - Held sweep clear pulses again on every update edge.
// - Full clear holds both accumulators at zero until released.
// - Low word at addresses 4 to 9, high word at A to F.
// - Three-bit mode field in control register at address 1F.
// - Written values take effect only on an update pulse.
module fsk_sweep_engine
  import fsk_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              clk_en_in,
  // Register byte port
  input  wire logic              reg_wr_in,
  input  wire logic [5:0]        reg_addr_in,
  input  wire logic [7:0]        reg_data_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  // Update and keying pins
  input  wire logic              io_update_in,
  input  wire logic              keying_input_in,
  // Phase accumulator result and destination flag
  output logic      [WORD_W-1:0] phase_increment_out,
  output logic      [WORD_W-1:0] phase_accumulator_out,
  output logic                   at_destination_out
);

  fsk_wr_type   wr_req;
  fsk_regs_type shadow;
  fsk_regs_type active;
  logic [2:0]   key_sync;
  logic [2:0]   upd_sync;
  logic         key_lvl;
  logic         key_prev;
  logic         key_edge;
  logic         upd_edge;
  logic         tri_prev;
  logic         tri_rise;
  logic         sclr_pulse;
  logic         ramp_up;
  logic         running;
  logic         tick;
  logic         restart;
  logic [WORD_W-1:0] sweep_accumulator;
  logic [WORD_W-1:0] next_sweep;
  logic [WORD_W-1:0] next_freq;
  logic [WORD_W-1:0] span;
  logic              reached;
  fsk_mode_type      mode;
  logic              tri_on;
  logic              fclr;

  assign wr_req = '{wr: reg_wr_in, addr: reg_addr_in, data: reg_data_in};
  assign mode   = fsk_mode_type'(active.control[CTRL_MODE_LSB +: 3]);
  assign tri_on = active.control[CTRL_TRI_BIT];
  assign fclr   = active.control[CTRL_FCLR_BIT];

  // Byte lane write into a 48-bit word, low byte at the lowest address
  function automatic logic [WORD_W-1:0] put_byte(input logic [WORD_W-1:0] w,
                                                  input logic [5:0] idx,
                                                  input logic [7:0] b);
    logic [WORD_W-1:0] r;
    r = w;
    r[idx[2:0]*8 +: 8] = b;
    return r;
  endfunction

  // Shadow registers loaded by byte writes
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shadow <= '{WORD_RESET, WORD_RESET, WORD_RESET, INTERVAL_RESET, CTRL_RESET};
    end else if (clk_en_in && wr_req.wr) begin
      if (wr_req.addr >= ADDR_LOW_TONE && wr_req.addr < ADDR_HIGH_TONE) begin
        shadow.low_tone_word <= put_byte(shadow.low_tone_word, wr_req.addr - ADDR_LOW_TONE, wr_req.data);
      end else if (wr_req.addr >= ADDR_HIGH_TONE && wr_req.addr < ADDR_STEP) begin
        shadow.high_tone_word <= put_byte(shadow.high_tone_word, wr_req.addr - ADDR_HIGH_TONE, wr_req.data);
      end else if (wr_req.addr >= ADDR_STEP && wr_req.addr < ADDR_STEP + 6'h06) begin
        shadow.step_word <= put_byte(shadow.step_word, wr_req.addr - ADDR_STEP, wr_req.data);
      end else if (wr_req.addr >= ADDR_INTERVAL && wr_req.addr < ADDR_INTERVAL + 6'h03) begin
        case (wr_req.addr - ADDR_INTERVAL)
          6'h00:   shadow.interval[7:0]   <= wr_req.data;
          6'h01:   shadow.interval[15:8]  <= wr_req.data;
          default: shadow.interval[19:16] <= wr_req.data[3:0];
        endcase
      end else if (wr_req.addr == ADDR_CONTROL) begin
        shadow.control <= wr_req.data;
      end
    end
  end

  // Read back of shadow bytes; unmapped addresses read zero
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in && reg_rd_in) begin
      if (reg_addr_in >= ADDR_LOW_TONE && reg_addr_in < ADDR_HIGH_TONE) begin
        reg_rdata_out <= shadow.low_tone_word[(reg_addr_in - ADDR_LOW_TONE)*8 +: 8];
      end else if (reg_addr_in >= ADDR_HIGH_TONE && reg_addr_in < ADDR_STEP) begin
        reg_rdata_out <= shadow.high_tone_word[(reg_addr_in - ADDR_HIGH_TONE)*8 +: 8];
      end else if (reg_addr_in >= ADDR_STEP && reg_addr_in < ADDR_STEP + 6'h06) begin
        reg_rdata_out <= shadow.step_word[(reg_addr_in - ADDR_STEP)*8 +: 8];
      end else if (reg_addr_in >= ADDR_INTERVAL && reg_addr_in < ADDR_INTERVAL + 6'h03) begin
        reg_rdata_out <= 8'(shadow.interval >> ((reg_addr_in - ADDR_INTERVAL)*8));
      end else if (reg_addr_in == ADDR_CONTROL) begin
        reg_rdata_out <= shadow.control;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_sync <= 3'b000;
      upd_sync <= 3'b000;
    end else if (clk_en_in) begin
      key_sync <= {key_sync[1:0], keying_input_in};
      upd_sync <= {upd_sync[1:0], io_update_in};
    end
  end

  assign key_lvl  = key_sync[1];
  assign key_edge = key_sync[1] ^ key_sync[2];
  assign upd_edge = upd_sync[1] & ~upd_sync[2];

  // Copy to the working set only on an update edge
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active <= '{WORD_RESET, WORD_RESET, WORD_RESET, INTERVAL_RESET, CTRL_RESET};
    end else if (clk_en_in && upd_edge) begin
      active <= shadow;
    end
  end

  // One-shot sweep clear on each update while the bit is set
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclr_pulse <= 1'b0;
    end else if (clk_en_in) begin
      sclr_pulse <= upd_edge & shadow.control[CTRL_SCLR_BIT];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tri_prev <= 1'b0;
      key_prev <= 1'b0;
    end else if (clk_en_in) begin
      tri_prev <= tri_on;
      key_prev <= key_lvl;
    end
  end

  assign tri_rise = tri_on & ~tri_prev & (mode == FSK_MODE_RAMPED);

  // Direction: keying in normal ramp, self-reversing in triangle
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ramp_up <= 1'b0;
    end else if (clk_en_in) begin
      if (tri_rise) begin
        ramp_up <= ~key_lvl;
      end else if (tri_on) begin
        if (reached) begin
          ramp_up <= ~ramp_up;
        end
      end else begin
        ramp_up <= key_lvl;
      end
    end
  end

  // Distance between the tone words; host keeps high above low
  assign span = active.high_tone_word - active.low_tone_word;
  assign reached = (sweep_accumulator == span);

  // Timer runs while moving; a keying edge restarts it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      running <= 1'b0;
    end else if (clk_en_in) begin
      if (mode != FSK_MODE_RAMPED || fclr) begin
        running <= 1'b0;
      end else if ((key_edge && !tri_on) || tri_rise || sclr_pulse) begin
        running <= 1'b1;
      end else if (reached && !tri_on) begin
        running <= 1'b0;
      end
    end
  end

  // Keying is ignored while the triangle sweep runs
  assign restart = (key_edge & ~tri_on) | tri_rise | sclr_pulse;

  fsk_rate_timer #(
    .CNT_W(INTERVAL_W)
  ) u_timer (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .run_in     (running),
    .restart_in (restart),
    .interval_in(active.interval),
    .tick_out   (tick)
  );

  // Accumulator counts distance from the start word of the current leg.
  // A reversal mirrors it so the frequency continues without a jump.
  always_comb begin
    next_sweep = sweep_accumulator;
    if ((key_edge && !tri_on && running) || (tri_on && reached && !tri_rise)) begin
      next_sweep = span - sweep_accumulator;
    end else if (tick && running) begin
      if (span - sweep_accumulator <= active.step_word) begin
        next_sweep = span;
      end else begin
        next_sweep = sweep_accumulator + active.step_word;
      end
    end
  end

  // Sweep accumulator with clears
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sweep_accumulator <= WORD_RESET;
    end else if (clk_en_in) begin
      if (fclr || sclr_pulse || tri_rise || mode != FSK_MODE_RAMPED) begin
        sweep_accumulator <= WORD_RESET;
      end else if (key_edge && !tri_on && !running) begin
        sweep_accumulator <= WORD_RESET;
      end else begin
        sweep_accumulator <= next_sweep;
      end
    end
  end

  // Frequency selection by mode
  always_comb begin
    case (mode)
      FSK_MODE_KEYED: begin
        next_freq = key_lvl ? active.high_tone_word : active.low_tone_word;
      end
      FSK_MODE_RAMPED: begin
        // Leg start is the opposite word of the direction travelled
        next_freq = ramp_up ? active.low_tone_word + sweep_accumulator
                            : active.high_tone_word - sweep_accumulator;
      end
      default: begin
        next_freq = active.low_tone_word;
      end
    endcase
  end

  // Only the increment changes; phase keeps running
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_increment_out   <= WORD_RESET;
      phase_accumulator_out <= WORD_RESET;
    end else if (clk_en_in) begin
      if (fclr) begin
        phase_increment_out   <= WORD_RESET;
        phase_accumulator_out <= WORD_RESET;
      end else begin
        phase_increment_out   <= next_freq;
        phase_accumulator_out <= phase_accumulator_out + phase_increment_out;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      at_destination_out <= 1'b0;
    end else if (clk_en_in) begin
      at_destination_out <= reached & (mode == FSK_MODE_RAMPED);
    end
  end

endmodule
`default_nettype wire

// File: fsk_sweep_engine_checker.sv
// Port-level assertions for the sweep engine
`timescale 1ns/1ps
`default_nettype none
module fsk_sweep_engine_checker
  import fsk_pkg::*;
(
  // Clock and inputs
  input wire logic              mclk_in,
  input wire logic              sys_rst_in,
  input wire logic              clk_en_in,
  input wire logic              reg_wr_in,
  input wire logic [5:0]        reg_addr_in,
  input wire logic [7:0]        reg_data_in,
  input wire logic              reg_rd_in,
  input wire logic              io_update_in,
  input wire logic              keying_input_in,
  // Outputs
  input wire logic [7:0]        reg_rdata_out,
  input wire logic [WORD_W-1:0] phase_increment_out,
  input wire logic [WORD_W-1:0] phase_accumulator_out,
  input wire logic              at_destination_out
);
  logic [7:0] low_byte;
  logic [3:0] quiet;
  logic       key_q;
  logic       rst_seen = 1'b0;
  // Flops only settle at the first edge of reset, so look from the second
  always @(posedge mclk_in) rst_seen <= sys_rst_in;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) low_byte <= 8'h00;
    else if (clk_en_in && reg_wr_in && reg_addr_in == ADDR_LOW_TONE) low_byte <= reg_data_in;
  end
  // Quiet span: keying pipeline and update syncs have drained
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_q <= 1'b0;
      quiet <= 4'h0;
    end else begin
      key_q <= keying_input_in;
      if (io_update_in || key_q != keying_input_in) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  phase_adds_a:
    assert property (clk_en_in |=> phase_accumulator_out == $past(phase_accumulator_out)
      + $past(phase_increment_out) || phase_accumulator_out == '0) else $error("phase did not add");
  freeze_holds_a:
    assert property (!clk_en_in |=> $stable(phase_accumulator_out) && $stable(phase_increment_out))
      else $error("state moved while frozen");
  unmapped_zero_a:
    assert property (clk_en_in && reg_rd_in && reg_addr_in > ADDR_CONTROL |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
  rdata_stands_a:
    assert property (!(clk_en_in && reg_rd_in) |=> $stable(reg_rdata_out)) else $error("read data moved");
  interval_width_a:
    assert property (clk_en_in && reg_rd_in && reg_addr_in == 6'h1c |=> reg_rdata_out[7:4] == 4'h0)
      else $error("interval wider than 20 bits");
  low_readback_a:
    assert property (clk_en_in && reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_LOW_TONE
      |=> reg_rdata_out == $past(low_byte)) else $error("low word readback wrong");
  dest_hold_a:
    assert property (at_destination_out && quiet >= 4'h8 |=> $stable(phase_increment_out))
      else $error("moved at destination");
  reset_zero_a:
    assert property (@(posedge mclk_in) disable iff (1'b0) sys_rst_in && rst_seen |-> phase_increment_out == '0
      && phase_accumulator_out == '0 && !at_destination_out) else $error("outputs not cleared");
endmodule
bind fsk_sweep_engine fsk_sweep_engine_checker fsk_sweep_engine_checker_inst (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .reg_wr_in(reg_wr_in),
  .reg_addr_in(reg_addr_in), .reg_data_in(reg_data_in), .reg_rd_in(reg_rd_in),
  .io_update_in(io_update_in), .keying_input_in(keying_input_in), .reg_rdata_out(reg_rdata_out),
  .phase_increment_out(phase_increment_out), .phase_accumulator_out(phase_accumulator_out),
  .at_destination_out(at_destination_out));
`default_nettype wire

// File: tb_fsk_sweep_engine.sv
// Self-checking bench for the sweep engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb_fsk_sweep_engine
  import fsk_pkg::*;
;
  logic              mclk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              clk_en_in = 1'b1;
  logic              wr, rd_s, upd, key, at_dest;
  logic              rd_seen = 1'b0;
  logic [5:0]        addr;
  logic [7:0]        data, rdata;
  logic [WORD_W-1:0] inc, acc, lo, hi, step, a;
  logic [7:0]        exp_q[$];
  int                fail_count = 0;
  int                checked = 0;
  integer            seed = 52667;
  always #2.5 mclk_in = ~mclk_in;
  fsk_sweep_engine fsk_sweep_engine_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_data_in(data), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .io_update_in(upd), .keying_input_in(key), .phase_increment_out(inc), .phase_accumulator_out(acc),
    .at_destination_out(at_dest));
  fsk_host_model fsk_host_model_inst (.mclk_in(mclk_in), .wr_out(wr), .rd_out(rd_s), .addr_out(addr),
    .data_out(data), .upd_out(upd), .key_out(key));
  always @(posedge mclk_in) begin
    if (rd_seen) `CHK(rdata, exp_q.pop_front(), "read data")
    rd_seen <= rd_s && clk_en_in;
  end
  task automatic rd(input logic [5:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    fsk_host_model_inst.rd(ad);
  endtask
  task automatic wait_for(input logic [47:0] v, input int lim);
    int c;
    c = 0;
    while (inc !== v && c < lim) begin
      @(posedge mclk_in);
      #1;
      c++;
    end
    `CHK(inc, v, "tone word")
  endtask
  task automatic ramp(input logic [47:0] tgt, input int stop, input int exp_n);
    logic [47:0] prev;
    logic [47:0] d;
    int gap;
    int n;
    prev = inc;
    gap = -1;
    n = 0;
    repeat (300) begin
      @(posedge mclk_in);
      #1;
      if (inc !== prev) begin
        d = (inc > prev) ? inc - prev : prev - inc;
        `CHK((inc === tgt) ? step : d, step, "step size")
        if (gap >= 0) `CHK(gap, 3, "step spacing")
        gap = 0;
        prev = inc;
        n++;
        if (n == stop) return;
      end else if (gap >= 0) gap++;
      if (at_dest === 1'b1 && inc === tgt) break;
    end
    `CHK(inc, tgt, "destination")
    if (exp_n > 0) `CHK(n, exp_n, "step count")
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(20000 * 5);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    lo = {16'h0000, 32'($random(seed))};
    step = {32'h0000_0000, 16'($random(seed)) | 16'h0100};
    hi = lo + 5 * step + (step >> 1);
    rd(ADDR_INTERVAL, 8'h01);
    fsk_host_model_inst.wr(ADDR_LOW_TONE, lo, 6);
    fsk_host_model_inst.wr(ADDR_HIGH_TONE, hi, 6);
    fsk_host_model_inst.wr(ADDR_CONTROL, 8'h01, 1);
    for (int i = 0; i < 6; i++) rd(ADDR_LOW_TONE + 6'(i), lo[8*i+:8]);
    rd(6'h30, 8'h00);
    fsk_host_model_inst.pulse(8);
    for (int i = 0; i < 3; i++) begin
      fsk_host_model_inst.key(i[0]);
      wait_for(i[0] ? hi : lo, 12);
    end
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    @(posedge mclk_in);
    #1 a = acc;
    repeat (4) begin
      @(posedge mclk_in);
      #1 `CHK(acc, a, "frozen")
    end
    @(posedge mclk_in);
    clk_en_in <= 1'b1;
    $display("test unramped done");
    fsk_host_model_inst.wr(ADDR_STEP, step, 6);
    fsk_host_model_inst.wr(ADDR_INTERVAL, 20'h0_0003, 3);
    fsk_host_model_inst.sweep_clear(8'h02);
    wait_for(lo, 300);
    fsk_host_model_inst.key(1'b1);
    ramp(hi, 0, 6);
    repeat (20) @(posedge mclk_in);
    #1 `CHK(inc, hi, "dwell")
    fsk_host_model_inst.key(1'b0);
    ramp(lo, 2, 0);
    fsk_host_model_inst.key(1'b1);
    // Reversal needs the keying pin to clear its synchroniser first
    repeat (4) @(posedge mclk_in);
    ramp(hi, 0, 3);
    $display("test ramp done");
    fsk_host_model_inst.wr(ADDR_CONTROL, 8'h42, 1);
    fsk_host_model_inst.pulse(0);
    wait_for(lo, 12);
    ramp(hi, 0, 6);
    fsk_host_model_inst.pulse(0);
    wait_for(lo, 12);
    ramp(hi, 0, 6);
    fsk_host_model_inst.wr(ADDR_CONTROL, 8'h22, 1);
    fsk_host_model_inst.pulse(0);
    ramp(lo, 0, 6);
    fsk_host_model_inst.key(1'b0);
    ramp(hi, 0, 6);
    $display("test triangle done");
    fsk_host_model_inst.wr(ADDR_CONTROL, 8'h82, 1);
    fsk_host_model_inst.pulse(8);
    repeat (3) begin
      @(posedge mclk_in);
      #1 `CHK(acc, 48'h0000_0000_0000, "full clear")
    end
    rd(ADDR_CONTROL, 8'h82);
    rd(6'h1c, 8'h00);
    rd(ADDR_INTERVAL, 8'h03);
    fsk_host_model_inst.wr(ADDR_CONTROL, 8'h00, 1);
    fsk_host_model_inst.pulse(0);
    wait_for(lo, 12);
    repeat (4) @(posedge mclk_in);
    $display("test clears done");
    print_verdict();
  end
endmodule
`default_nettype wire
